// *** verilog/jtg_map.vh ***
`ifndef JTG_MAP_VH
`define JTG_MAP_VH

`define JTG_IR_LEN 10
`define JTG_IR_CAPTURE 10'h001
`define JTG_BSR_MAX 816
`define JTG_BSR_LEN0 10'd240
`define JTG_BSR_LEN1 10'd480
`define JTG_BSR_LEN2 10'd636
`define JTG_BSR_LEN3 10'd816
`define JTG_ID_LEN 10'd32
`define JTG_UCODE_LEN 10'd32
`define JTG_FLASH_AW 16
`define JTG_FLASH_DW 16
`define JTG_FLASH_LEN 10'd16

`define JTG_I_CLAMP 10'h00a
`define JTG_I_USER_A 10'h00c
`define JTG_I_USER_B 10'h00e
`define JTG_I_EXTEST 10'h00f
`define JTG_I_SAMPLE 10'h005
`define JTG_I_DEVICE_IDENTIFICATION 10'h006
`define JTG_I_USER_CODE_WORD 10'h007
`define JTG_I_HIGHZ 10'h00b
`define JTG_I_BYPASS 10'h3ff
`define JTG_I_ISP_ENABLE 10'h2cc
`define JTG_I_ISP_DISABLE 10'h201
`define JTG_I_ISP_ADDRESS 10'h203
`define JTG_I_ISP_PROGRAM 10'h2f4
`define JTG_I_ISP_ERASE 10'h2f2
`define JTG_I_ISP_READ 10'h205

`define JTG_ID_VERSION 4'h0
`define JTG_ID_PART 16'h1234
`define JTG_ID_MAKER 11'h155
`define JTG_USER_CODE 32'hffffffff

`endif

// *** verilog/jtg_sync.v ***
`default_nettype none
module jtg_sync #(
  parameter W = 3
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  integer i;

  // A bit only moves once the second and third stages agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/jtg_tap.v ***
`include "jtg_map.vh"
`default_nettype none
module jtg_tap #(
  parameter DENSITY = 1
) (
  input wire clk,
  input wire rst_n,
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdo_oe,
  input wire [`JTG_BSR_MAX-1:0] pin_in,
  output reg [`JTG_BSR_MAX-1:0] pin_out,
  output reg pin_override,
  output reg pin_hiz,
  output reg user_chain_a_sel,
  output reg user_chain_b_sel,
  output reg user_capture,
  output reg user_shift,
  output reg user_update,
  output reg user_tdi,
  input wire user_tdo,
  output reg isp_active,
  output reg [`JTG_FLASH_AW-1:0] flash_addr,
  output reg [`JTG_FLASH_DW-1:0] flash_wdata,
  output reg flash_prog,
  output reg flash_erase,
  input wire [`JTG_FLASH_DW-1:0] flash_rdata
);
  localparam [3:0] ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UP_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb;
  localparam [3:0] ST_EX1_IR = 4'hc, ST_PA_IR = 4'hd, ST_EX2_IR = 4'he, ST_UP_IR = 4'hf;

  wire [2:0] pins;
  reg tck_prev_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [`JTG_IR_LEN-1:0] ir_sh_reg;
  reg [`JTG_IR_LEN-1:0] test_instruction_reg;
  reg [`JTG_BSR_MAX-1:0] dr_sh_reg;
  reg [`JTG_BSR_MAX-1:0] dr_sh_next;
  reg [9:0] len;
  integer i;

  // Pins have their own dedicated synchroniser and reach nothing else
  jtg_sync #(.W(3)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({tck, tms, tdi}),
    .dout(pins)
  );

  wire tck_rise = pins[2] & ~tck_prev_reg;
  wire tck_fall = ~pins[2] & tck_prev_reg;
  wire tms_s = pins[1];
  wire tdi_s = pins[0];

  function [9:0] bsr_len;
    input integer d;
    begin
      case (d)
        0: bsr_len = `JTG_BSR_LEN0;
        1: bsr_len = `JTG_BSR_LEN1;
        2: bsr_len = `JTG_BSR_LEN2;
        default: bsr_len = `JTG_BSR_LEN3;
      endcase
    end
  endfunction

  // Codes outside the set fall to bypass; the controller must avoid them anyway
  function [9:0] dr_len;
    input [`JTG_IR_LEN-1:0] ins;
    begin
      if (ins == `JTG_I_EXTEST || ins == `JTG_I_SAMPLE) begin
        dr_len = bsr_len(DENSITY);
      end else if (ins == `JTG_I_DEVICE_IDENTIFICATION) begin
        dr_len = `JTG_ID_LEN;
      end else if (ins == `JTG_I_USER_CODE_WORD) begin
        dr_len = `JTG_UCODE_LEN;
      end else if (ins == `JTG_I_ISP_ADDRESS) begin
        dr_len = `JTG_FLASH_LEN;
      end else if (ins == `JTG_I_ISP_PROGRAM || ins == `JTG_I_ISP_READ) begin
        dr_len = `JTG_FLASH_LEN;
      end else begin
        dr_len = 10'd1;
      end
    end
  endfunction

  function is_user;
    input [`JTG_IR_LEN-1:0] ins;
    begin
      is_user = (ins == `JTG_I_USER_A) || (ins == `JTG_I_USER_B);
    end
  endfunction

  always @* begin
    case (state_reg)
      ST_RESET: state_next = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_next = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_next = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_next = tms_s ? ST_UP_DR : ST_PA_DR;
      ST_PA_DR: state_next = tms_s ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_next = tms_s ? ST_UP_DR : ST_SH_DR;
      ST_UP_DR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_next = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_next = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_next = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_next = tms_s ? ST_UP_IR : ST_PA_IR;
      ST_PA_IR: state_next = tms_s ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_next = tms_s ? ST_UP_IR : ST_SH_IR;
      default: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  // Serial entry sits at the top of the selected length, exit at bit 0
  always @* begin
    len = dr_len(test_instruction_reg);
    for (i = 0; i < `JTG_BSR_MAX; i = i + 1) begin
      if (i == len - 1) begin
        dr_sh_next[i] = tdi_s;
      end else if (i < len - 1) begin
        dr_sh_next[i] = dr_sh_reg[i+1];
      end else begin
        dr_sh_next[i] = 1'b0;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_prev_reg <= 1'b0;
      state_reg <= ST_RESET;
      ir_sh_reg <= `JTG_IR_CAPTURE;
      test_instruction_reg <= `JTG_I_DEVICE_IDENTIFICATION;
      dr_sh_reg <= {`JTG_BSR_MAX{1'b0}};
      pin_out <= {`JTG_BSR_MAX{1'b0}};
      isp_active <= 1'b0;
      flash_addr <= {`JTG_FLASH_AW{1'b0}};
      flash_wdata <= {`JTG_FLASH_DW{1'b0}};
      tdo <= 1'b1;
      tdo_oe <= 1'b0;
    end else begin
      tck_prev_reg <= pins[2];
      if (tck_rise) begin
        state_reg <= state_next;
        case (state_reg)
          ST_RESET: begin
            test_instruction_reg <= `JTG_I_DEVICE_IDENTIFICATION;
            isp_active <= 1'b0;
          end
          ST_CAP_IR: ir_sh_reg <= `JTG_IR_CAPTURE;
          ST_SH_IR: ir_sh_reg <= {tdi_s, ir_sh_reg[`JTG_IR_LEN-1:1]};
          ST_UP_IR: begin
            test_instruction_reg <= ir_sh_reg;
            if (ir_sh_reg == `JTG_I_ISP_ENABLE) begin
              isp_active <= 1'b1;
            end else if (ir_sh_reg == `JTG_I_ISP_DISABLE) begin
              isp_active <= 1'b0;
            end
          end
          ST_CAP_DR: begin
            if (test_instruction_reg == `JTG_I_DEVICE_IDENTIFICATION) begin
              dr_sh_reg[31:0] <= {`JTG_ID_VERSION, `JTG_ID_PART, `JTG_ID_MAKER, 1'b1};
            end else if (test_instruction_reg == `JTG_I_USER_CODE_WORD) begin
              dr_sh_reg[31:0] <= `JTG_USER_CODE;
            end else if (test_instruction_reg == `JTG_I_EXTEST ||
                         test_instruction_reg == `JTG_I_SAMPLE) begin
              dr_sh_reg <= pin_in;
            end else if (test_instruction_reg == `JTG_I_ISP_READ) begin
              dr_sh_reg[`JTG_FLASH_DW-1:0] <= flash_rdata;
            end else begin
              dr_sh_reg[0] <= 1'b0;
            end
          end
          ST_SH_DR: dr_sh_reg <= dr_sh_next;
          ST_UP_DR: begin
            if (test_instruction_reg == `JTG_I_EXTEST ||
                test_instruction_reg == `JTG_I_SAMPLE) begin
              pin_out <= dr_sh_reg;
            end else if (isp_active && test_instruction_reg == `JTG_I_ISP_ADDRESS) begin
              flash_addr <= dr_sh_reg[`JTG_FLASH_AW-1:0];
            end else if (isp_active && test_instruction_reg == `JTG_I_ISP_PROGRAM) begin
              flash_wdata <= dr_sh_reg[`JTG_FLASH_DW-1:0];
            end
          end
          default: begin
          end
        endcase
      end
      // Output moves half a bit later so the controller samples a settled level
      if (tck_fall) begin
        tdo_oe <= (state_reg == ST_SH_IR) || (state_reg == ST_SH_DR);
        if (state_reg == ST_SH_IR) begin
          tdo <= ir_sh_reg[0];
        end else if (is_user(test_instruction_reg)) begin
          tdo <= user_tdo;
        end else begin
          tdo <= dr_sh_reg[0];
        end
      end
    end
  end

  // Pin control and the flash pulses; the pulse length is the controller's idle time
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_override <= 1'b0;
      pin_hiz <= 1'b0;
      user_chain_a_sel <= 1'b0;
      user_chain_b_sel <= 1'b0;
      user_capture <= 1'b0;
      user_shift <= 1'b0;
      user_update <= 1'b0;
      user_tdi <= 1'b0;
      flash_prog <= 1'b0;
      flash_erase <= 1'b0;
    end else begin
      // Pull-up and bus-hold controls live outside and are never touched here
      pin_override <= (test_instruction_reg == `JTG_I_EXTEST) ||
                      (test_instruction_reg == `JTG_I_CLAMP) || isp_active;
      pin_hiz <= (test_instruction_reg == `JTG_I_HIGHZ);
      user_chain_a_sel <= (test_instruction_reg == `JTG_I_USER_A);
      user_chain_b_sel <= (test_instruction_reg == `JTG_I_USER_B);
      user_capture <= tck_rise && is_user(test_instruction_reg) && state_reg == ST_CAP_DR;
      user_shift <= tck_rise && is_user(test_instruction_reg) && state_reg == ST_SH_DR;
      user_update <= tck_rise && is_user(test_instruction_reg) && state_reg == ST_UP_DR;
      user_tdi <= tdi_s;
      flash_prog <= isp_active && state_reg == ST_IDLE &&
                    test_instruction_reg == `JTG_I_ISP_PROGRAM;
      flash_erase <= isp_active && state_reg == ST_IDLE &&
                     test_instruction_reg == `JTG_I_ISP_ERASE;
    end
  end
endmodule
`default_nettype wire

// *** tb/jtg_tap_properties.sv ***
`include "jtg_map.vh"
`default_nettype none
module jtg_tap_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [`JTG_BSR_MAX-1:0] pin_out,
  input wire logic pin_override,
  input wire logic user_chain_a_sel,
  input wire logic user_chain_b_sel,
  input wire logic user_capture,
  input wire logic user_shift,
  input wire logic isp_active,
  input wire logic flash_prog,
  input wire logic flash_erase
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Synchroniser delay means the pin level three or two cycles back tells the edge
  sequence s_after_rise;
    $past(tck, 3);
  endsequence
  sequence s_after_fall;
    !$past(tck, 2);
  endsequence
  property p_tdo_fall;
    $changed(tdo) |-> s_after_fall;
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off a tck fall");
  property p_oe_fall;
    $changed(tdo_oe) |-> s_after_fall;
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("tdo_oe moved off a tck fall");
  property p_pin_rise;
    $changed(pin_out) |-> s_after_rise;
  endproperty
  a_pin_rise: assert property (p_pin_rise) else $error("pin_out moved off a tck rise");
  property p_isp_rise;
    $changed(isp_active) |-> s_after_rise;
  endproperty
  a_isp_rise: assert property (p_isp_rise) else $error("isp_active moved off a rise");
  property p_ushift;
    user_shift |-> (user_chain_a_sel || user_chain_b_sel) ##1 !user_shift;
  endproperty
  a_ushift: assert property (p_ushift) else $error("user_shift pulse wrong");
  property p_ucap;
    user_capture |-> (user_chain_a_sel || user_chain_b_sel) && !user_shift ##1 !user_capture;
  endproperty
  a_ucap: assert property (p_ucap) else $error("user_capture pulse wrong");
  property p_usel;
    !(user_chain_a_sel && user_chain_b_sel);
  endproperty
  a_usel: assert property (p_usel) else $error("both user chains selected");
  property p_isp_pins;
    isp_active && $past(isp_active) |-> pin_override;
  endproperty
  a_isp_pins: assert property (p_isp_pins) else $error("pins free during isp");
  property p_flash;
    flash_prog || flash_erase |-> isp_active && !(flash_prog && flash_erase);
  endproperty
  a_flash: assert property (p_flash) else $error("flash strobe outside isp");
endmodule
`default_nettype wire

// *** tb/jtg_ctl_model.sv ***
`default_nettype none
module jtg_ctl (
  input wire logic clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  output logic done,
  output logic [1023:0] res
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {tck, tms, tdi, done} = 4'h4;
  // Mode and data move with the fall; tdo is read one clk after the rise, since the
  // device's three-stage pin synchroniser puts its answer over four clk behind the fall
  task automatic bit_io(input logic m, d, output logic q);
    @(negedge clk);
    tck = 0;
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk);
    tck = 1;
    @(negedge clk);
    q = tdo;
    repeat (2) @(negedge clk);
  endtask
  // Hold in idle; the real erase and program pulses are far longer
  task automatic idle(input int n);
    logic q;
    repeat (n) bit_io(0, 0, q);
  endtask
  task automatic tap_reset;
    logic q;
    repeat (5) bit_io(1, 0, q);
    bit_io(0, 0, q);
  endtask
  task automatic scan(input bit ir, input int len, input logic [1023:0] din);
    logic q;
    res = '0;
    bit_io(1, 0, q);
    if (ir) bit_io(1, 0, q);
    bit_io(0, 0, q);
    bit_io(0, 0, q);
    for (int i = 0; i < len; i++) begin
      bit_io(i == len - 1, din[i], q);
      res[i] = q;
    end
    bit_io(1, 0, q);
    bit_io(0, 0, q);
    // The update only lands some clk after the last rise; let it settle before checks
    repeat (6) @(negedge clk);
    done = 1;
    @(negedge clk);
    done = 0;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_jtg_tap.sv ***
`include "jtg_map.vh"
`default_nettype none
module tb_jtg_tap;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID = {`JTG_ID_VERSION, `JTG_ID_PART, `JTG_ID_MAKER, 1'b1};
  logic clk = 0, rst_n = 0, tck, tms, tdi, tdo, oe, ovr, hiz, ua, ub, ucap, ush, utdi;
  logic in_system_programming, fprog, ferase, done, uupd;
  logic oe_hi = 1'b0;
  integer n_upd = 0;
  logic [`JTG_BSR_MAX-1:0] pin_in, pin_out;
  logic [15:0] faddr, fwd, frd;
  logic [1023:0] res, r, m, bsr;
  logic [1023:0] q_exp[$], q_msk[$];
  logic [3:0] uch;
  logic [9:0] ops[3];
  integer seed = 2, n_mismatch = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  jtg_tap #(.DENSITY(1)) dut_u (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(oe), .pin_in(pin_in), .pin_out(pin_out), .pin_override(ovr),
    .pin_hiz(hiz), .user_chain_a_sel(ua), .user_chain_b_sel(ub), .user_capture(ucap),
    .user_shift(ush), .user_update(uupd), .user_tdi(utdi), .user_tdo(uch[0]),
    .isp_active(in_system_programming), .flash_addr(faddr), .flash_wdata(fwd), .flash_prog(fprog),
    .flash_erase(ferase), .flash_rdata(frd));
  jtg_ctl ctl_u (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .done(done),
    .res(res));
  // Four-cell user chain, a different capture value per chain
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) uch <= 4'h0;
    else if (ucap) uch <= ua ? 4'ha : 4'h5;
    else if (ush) uch <= {utdi, uch[3:1]};
  end
  // Tally update pulses and note whether the output enable ever rose
  always @(posedge clk) begin
    if (uupd === 1'b1) n_upd <= n_upd + 1;
    if (oe === 1'b1) oe_hi <= 1'b1;
  end
  task automatic chk(input string nm, input logic [1023:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic scan(input bit ir, input int len, input logic [1023:0] d, e, k = '1);
    q_exp.push_back(e);
    q_msk.push_back(k);
    ctl_u.scan(ir, len, d);
  endtask
  task automatic ir(input logic [9:0] c);
    scan(1, `JTG_IR_LEN, c, `JTG_IR_CAPTURE);
  endtask
  task automatic newr;
    for (int k = 0; k < 32; k++) r[k*32 +: 32] = $random(seed);
  endtask
  always @(posedge clk) begin
    if (done === 1'b1) begin
      m = q_msk.pop_front();
      chk("tdo", res & m, q_exp.pop_front() & m);
    end
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    results;
  end
  initial begin
    for (int k = 0; k < `JTG_BSR_MAX; k++) pin_in[k] = $random(seed);
    frd = $random(seed);
    repeat (6) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    ctl_u.tap_reset;
    scan(0, 32, 0, ID);
    chk("tdo_oe", {oe_hi, oe}, 2'b10);
    ir(`JTG_I_USER_CODE_WORD);
    newr;
    scan(0, 64, r, {r[31:0], `JTG_USER_CODE});
    ir(`JTG_I_SAMPLE);
    newr;
    scan(0, `JTG_BSR_LEN1 + 16, r, {r[15:0], pin_in[`JTG_BSR_LEN1-1:0]});
    bsr = r[`JTG_BSR_LEN1+15:16];
    chk("pin_out", pin_out, bsr);
    ops = '{`JTG_I_CLAMP, `JTG_I_HIGHZ, `JTG_I_BYPASS};
    foreach (ops[n]) begin
      ir(ops[n]);
      newr;
      scan(0, 8, r, {r[6:0], 1'b0});
      chk("pin_override", ovr, ops[n] == `JTG_I_CLAMP);
      chk("pin_hiz", hiz, ops[n] == `JTG_I_HIGHZ);
      chk("pin_out", pin_out, bsr);
    end
    for (int k = 0; k < 2; k++) begin
      ir(k ? `JTG_I_USER_B : `JTG_I_USER_A);
      newr;
      scan(0, 8, r, {r[3:0], k ? 4'h5 : 4'ha});
      chk("user_chain_b_sel", ub, k);
    end
    chk("user_update", n_upd, 2);
    // Address load is refused before programming mode is entered
    ir(`JTG_I_ISP_ADDRESS);
    newr;
    // Only the first bit out is pinned: these registers capture a zero there
    scan(0, 16, r, 0, 1);
    chk("flash_addr", faddr, 0);
    ir(`JTG_I_ISP_ENABLE);
    chk("isp_active", in_system_programming, 1);
    chk("pin_override", ovr, 1);
    ir(`JTG_I_DEVICE_IDENTIFICATION);
    scan(0, 32, 0, ID);
    ir(`JTG_I_ISP_ERASE);
    chk("flash_erase", ferase, 1);
    ctl_u.idle(8);
    ir(`JTG_I_ISP_ADDRESS);
    newr;
    scan(0, 16, r, 0, 1);
    chk("flash_addr", faddr, r[15:0]);
    ir(`JTG_I_ISP_PROGRAM);
    newr;
    scan(0, 16, r, 0, 1);
    chk("flash_wdata", fwd, r[15:0]);
    chk("flash_prog", fprog, 1);
    ctl_u.idle(8);
    ir(`JTG_I_ISP_READ);
    scan(0, 16, 0, frd);
    ir(`JTG_I_ISP_DISABLE);
    chk("isp_active", in_system_programming, 0);
    results;
  end
endmodule
bind jtg_tap jtg_tap_props props_u (.clk(clk), .rst_n(rst_n), .tck(tck), .tdo(tdo),
  .tdo_oe(tdo_oe), .pin_out(pin_out), .pin_override(pin_override),
  .user_chain_a_sel(user_chain_a_sel), .user_chain_b_sel(user_chain_b_sel),
  .user_capture(user_capture), .user_shift(user_shift), .isp_active(isp_active),
  .flash_prog(flash_prog), .flash_erase(flash_erase));
`default_nettype wire
